// ===== rtl/tcwm_pkg.sv
package tcwm_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_COMPARE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // Control register fields
    localparam int CTRL_WAVE_LSB = 0;
    localparam int CTRL_COM_LSB = 2;
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_DIR_BIT = 8;
    localparam int CTRL_PORT_BIT = 9;
    // Status register fields, write one to clear
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_CMP_BIT = 1;
    // Counter extremes
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // Waveform modes
    typedef enum logic [1:0] {
        TCWM_NORMAL = 2'b00,
        TCWM_PHASE = 2'b01,
        TCWM_CLEAR_ON_MATCH = 2'b10,
        TCWM_FAST_PWM = 2'b11
    } tcwm_wave_t;
    // Compare output modes
    localparam logic [1:0] COM_NONE = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage

// ===== rtl/tcwm_timer.sv
`timescale 1ns/10ps
module tcwm_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Prescaled timer tick enable
    input wire logic timer_tick,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port pin
    output logic pin_out,
    output logic pin_oe,
    // Status levels
    output logic overflow_flag,
    output logic compare_match_flag
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_output_mode;
    logic compare_pin_direction_bit;
    logic port_value;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic compare_output_bit;
    logic block_match;
    logic acked;
    logic wr_go;
    logic rd_go;
    logic is_pwm;
    logic at_top;
    logic match_now;
    logic next_force;
    logic [31:0] next_readdata;

    // Applies a compare output action to the current bit
    function automatic logic com_action(input logic [1:0] com, input logic b);
        case (com)
            tcwm_pkg::COM_TOGGLE: com_action = ~b;
            tcwm_pkg::COM_CLEAR: com_action = 1'b0;
            tcwm_pkg::COM_SET: com_action = 1'b1;
            default: com_action = b;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the access completes
    assign wr_go = avs_write & acked;
    assign rd_go = avs_read & acked;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acked <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            acked <= (avs_read | avs_write) & ~acked;
            avs_waitrequest <= ~((avs_read | avs_write) & ~acked);
        end
    end

    // Read data mux, unmapped reads return zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            tcwm_pkg::ADDR_CTRL: begin
                next_readdata[tcwm_pkg::CTRL_WAVE_LSB +: 2] = waveform_mode_select;
                next_readdata[tcwm_pkg::CTRL_COM_LSB +: 2] = compare_output_mode;
                next_readdata[tcwm_pkg::CTRL_DIR_BIT] = compare_pin_direction_bit;
                next_readdata[tcwm_pkg::CTRL_PORT_BIT] = port_value;
            end
            tcwm_pkg::ADDR_COUNT: next_readdata[7:0] = counter_value;
            tcwm_pkg::ADDR_COMPARE: next_readdata[7:0] = compare_buffer;
            tcwm_pkg::ADDR_STATUS: begin
                next_readdata[tcwm_pkg::STAT_OVF_BIT] = overflow_flag;
                next_readdata[tcwm_pkg::STAT_CMP_BIT] = compare_match_flag;
                next_readdata[tcwm_pkg::STAT_CMP_BIT + 1] = compare_output_bit;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~acked) begin
            avs_readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_mode_select <= 2'h0;
            compare_output_mode <= 2'h0;
            compare_pin_direction_bit <= 1'b0;
            port_value <= 1'b0;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_CTRL) begin
            // Mode field steers counting, output mode only the waveform
            waveform_mode_select <= avs_writedata[tcwm_pkg::CTRL_WAVE_LSB +: 2];
            compare_output_mode <= avs_writedata[tcwm_pkg::CTRL_COM_LSB +: 2];
            compare_pin_direction_bit <= avs_writedata[tcwm_pkg::CTRL_DIR_BIT];
            port_value <= avs_writedata[tcwm_pkg::CTRL_PORT_BIT];
        end
    end

    // Force strobe, only honoured outside PWM modes
    assign is_pwm = waveform_mode_select[0];
    assign next_force = wr_go && avs_address == tcwm_pkg::ADDR_CTRL &&
                        avs_writedata[tcwm_pkg::CTRL_FORCE_BIT] && !is_pwm;

    ////////////////////////////////////////////////////////////////////////
    // Compare value: buffered in PWM, direct otherwise
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_buffer <= 8'h00;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_COMPARE) begin
            compare_buffer <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_value <= 8'h00;
        end else if (!is_pwm) begin
            compare_value <= compare_buffer;
        end else if (timer_tick && at_top) begin
            compare_value <= compare_buffer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Top of the sequence for the current mode
    always_comb begin
        if (waveform_mode_select == tcwm_pkg::TCWM_CLEAR_ON_MATCH) begin
            at_top = counter_value == compare_value;
        end else begin
            at_top = counter_value == tcwm_pkg::CNT_MAX;
        end
    end

    // Match unless a counter write blocks the next tick
    assign match_now = (counter_value == compare_value) && !block_match;

    // Counter; a software write overrides counting
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            counter_value <= tcwm_pkg::CNT_BOTTOM;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_COUNT) begin
            counter_value <= avs_writedata[7:0];
        end else if (timer_tick) begin
            if (waveform_mode_select == tcwm_pkg::TCWM_CLEAR_ON_MATCH &&
                match_now) begin
                counter_value <= tcwm_pkg::CNT_BOTTOM;
            end else begin
                // Wrap through max in every mode
                counter_value <= counter_value + 8'h01;
            end
        end
    end

    // Match blocker: armed by a counter write, spent on the next tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            block_match <= 1'b0;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_COUNT) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: set wins over a write-one clear
    // Match seen in this tick period sets the flag at the closing tick edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_match_flag <= 1'b0;
        end else if (timer_tick && match_now) begin
            compare_match_flag <= 1'b1;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_STATUS &&
                     avs_writedata[tcwm_pkg::STAT_CMP_BIT]) begin
            compare_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (timer_tick && counter_value == tcwm_pkg::CNT_MAX &&
                     !(wr_go && avs_address == tcwm_pkg::ADDR_COUNT)) begin
            // Max to bottom in every mode: normal, phase, clear-on-match, fast PWM
            overflow_flag <= 1'b1;
        end else if (wr_go && avs_address == tcwm_pkg::ADDR_STATUS &&
                     avs_writedata[tcwm_pkg::STAT_OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare output bit; force does not touch flags or counter
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_output_bit <= 1'b0;
        end else if (next_force) begin
            // Action from the output mode written with the strobe
            compare_output_bit <= com_action(
                avs_writedata[tcwm_pkg::CTRL_COM_LSB +: 2],
                compare_output_bit);
        end else if (timer_tick) begin
            if (waveform_mode_select == tcwm_pkg::TCWM_FAST_PWM) begin
                if (compare_output_mode[1] && match_now &&
                    compare_value != tcwm_pkg::CNT_MAX) begin
                    // Mode 2 clears, mode 3 sets on match
                    compare_output_bit <= compare_output_mode[0];
                end else if (compare_output_mode[1] &&
                             counter_value == tcwm_pkg::CNT_MAX) begin
                    // Opposite level at bottom
                    compare_output_bit <= ~compare_output_mode[0];
                end else if (match_now) begin
                    compare_output_bit <= com_action(compare_output_mode,
                                                     compare_output_bit);
                end
            end else if (match_now) begin
                // Set, clear, toggle or hold at match
                compare_output_bit <= com_action(compare_output_mode,
                                                 compare_output_bit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin override and direction, registered
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_out <= (|compare_output_mode) ? compare_output_bit
                                              : port_value;
            pin_oe <= compare_pin_direction_bit;
        end
    end

endmodule

// ===== sim/tcwm_timer_asserts.sv
`timescale 1ns/10ps
module tcwm_timer_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic timer_tick,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic overflow_flag,
    input wire logic compare_match_flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic req;
    logic st_wr;
    logic ct_wr;
    // Bus decode
    assign req = avs_read || avs_write;
    assign st_wr = avs_write && avs_address == tcwm_pkg::ADDR_STATUS;
    assign ct_wr = avs_write && !avs_waitrequest
        && avs_address == tcwm_pkg::ADDR_CTRL;
    ////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($rose(rst_b) |-> !pin_out && !pin_oe
        && !overflow_flag && !compare_match_flag)
        else $error("Outputs not clear after reset");
    a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer not after one wait cycle");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Bus answer held too long");
    a_idle_wait: assert property (!req |=> avs_waitrequest)
        else $error("Bus answered without request");
    a_ovf_sticky: assert property (overflow_flag && !st_wr |=> overflow_flag)
        else $error("Overflow flag dropped by itself");
    a_cmp_sticky: assert property (compare_match_flag && !st_wr
        |=> compare_match_flag) else $error("Match flag dropped by itself");
    a_ovf_tick: assert property ($rose(overflow_flag) |-> $past(timer_tick))
        else $error("Overflow flag set without tick");
    a_cmp_tick: assert property ($rose(compare_match_flag)
        |-> $past(timer_tick)) else $error("Match flag set without tick");
    a_dir_drive: assert property (ct_wr
        && avs_writedata[tcwm_pkg::CTRL_DIR_BIT] |-> ##[1:2] pin_oe)
        else $error("Pin enable does not follow direction bit");
    a_port_pass: assert property (ct_wr && avs_writedata[tcwm_pkg::CTRL_PORT_BIT]
        && avs_writedata[tcwm_pkg::CTRL_COM_LSB +: 2] == tcwm_pkg::COM_NONE
        |-> ##[1:2] pin_out)
        else $error("Port value not on pin");
endmodule
bind tcwm_timer tcwm_timer_asserts u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .timer_tick(timer_tick), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .pin_out(pin_out),
    .avs_waitrequest(avs_waitrequest), .pin_oe(pin_oe),
    .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

// ===== sim/timer_compare_waveform_modes_test.sv
`timescale 1ns/10ps
module timer_compare_waveform_modes_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic timer_tick = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pin_out;
    logic pin_oe;
    logic overflow_flag;
    logic compare_match_flag;
    logic [31:0] q;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [3:0] A_CT = tcwm_pkg::ADDR_CTRL;
    localparam logic [3:0] A_CN = tcwm_pkg::ADDR_COUNT;
    localparam logic [3:0] A_CP = tcwm_pkg::ADDR_COMPARE;
    localparam logic [3:0] A_ST = tcwm_pkg::ADDR_STATUS;
    // Block under test
    tcwm_timer u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .timer_tick(timer_tick), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_out(pin_out),
        .pin_oe(pin_oe), .overflow_flag(overflow_flag),
        .compare_match_flag(compare_match_flag));
    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // Timer ticks on n consecutive clocks
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge core_clk);
            timer_tick <= 1'b1;
        end
        @(posedge core_clk);
        timer_tick <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge core_clk);
    endtask
    function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] c,
        input logic f, input logic d, input logic p);
        cw = 32'h0;
        cw[tcwm_pkg::CTRL_WAVE_LSB +: 2] = m;
        cw[tcwm_pkg::CTRL_COM_LSB +: 2] = c;
        cw[tcwm_pkg::CTRL_FORCE_BIT] = f;
        cw[tcwm_pkg::CTRL_DIR_BIT] = d;
        cw[tcwm_pkg::CTRL_PORT_BIT] = p;
    endfunction
    ////////////////////////////////////////////////////////////////
    task automatic t_force();
        wr(A_CN, 32'h40);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_NONE, 1'b0, 1'b0, 1'b1));
        settle();
        check(32'({pin_out, pin_oe}), 32'h2);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_SET, 1'b1, 1'b0, 1'b0));
        settle();
        check(32'({pin_out, pin_oe}), 32'h2);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_CLEAR, 1'b1, 1'b1, 1'b1));
        settle();
        check(32'({pin_out, pin_oe}), 32'h1);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_TOGGLE, 1'b1, 1'b1, 1'b0));
        rc(A_ST, 32'h4);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_NONE, 1'b1, 1'b1, 1'b0));
        rc(A_ST, 32'h4);
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_TOGGLE, 1'b1, 1'b1, 1'b0));
        rc(A_ST, 32'h0);
        rc(A_CN, 32'h40);
    endtask
    task automatic t_normal();
        wr(A_CN, 32'hfe);
        tk(1);
        rc(A_CN, 32'hff);
        check(32'(overflow_flag), 32'h0);
        tk(1);
        rc(A_CN, 32'h0);
        tk(3);
        check(32'(overflow_flag), 32'h1);
    endtask
    task automatic t_ctc();
        wr(A_CT, cw(2'h0, tcwm_pkg::COM_CLEAR, 1'b1, 1'b1, 1'b0));
        wr(A_CP, 32'h3);
        wr(A_CT, cw(tcwm_pkg::TCWM_CLEAR_ON_MATCH, tcwm_pkg::COM_TOGGLE,
            1'b0, 1'b1, 1'b0));
        wr(A_CN, 32'h0);
        wr(A_ST, 32'h3);
        tk(3);
        rc(A_CN, 32'h3);
        rc(A_ST, 32'h0);
        tk(1);
        rc(A_CN, 32'h0);
        rc(A_ST, 32'h6);
        check(32'(pin_out), 32'h1);
        wr(A_ST, 32'h2);
        tk(4);
        rc(A_ST, 32'h2);
        wr(A_CN, 32'h3);
        wr(A_ST, 32'h3);
        tk(1);
        rc(A_CN, 32'h4);
        tk(251);
        rc(A_ST, 32'h0);
        tk(1);
        rc(A_ST, 32'h1);
        rc(A_CN, 32'h0);
    endtask
    task automatic t_pwm();
        wr(A_CT, cw(tcwm_pkg::TCWM_FAST_PWM, tcwm_pkg::COM_CLEAR,
            1'b0, 1'b1, 1'b0));
        wr(A_CN, 32'hfd);
        wr(A_CP, 32'h10);
        wr(A_ST, 32'h3);
        tk(2);
        rc(A_CN, 32'hff);
        tk(1);
        rc(A_ST, 32'h5);
        tk(4);
        rc(A_ST, 32'h5);
        tk(12);
        rc(A_ST, 32'h5);
        tk(1);
        rc(A_ST, 32'h3);
        check(32'(pin_out), 32'h0);
        wr(A_CT, cw(tcwm_pkg::TCWM_FAST_PWM, tcwm_pkg::COM_SET,
            1'b0, 1'b1, 1'b0));
        tk(239);
        rc(A_CN, 32'h0);
        tk(17);
        rc(A_CN, 32'h11);
        rc(A_ST, 32'h7);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        check(32'({pin_out, pin_oe, overflow_flag}), 32'h0);
        rc(A_ST, 32'h0);
        rc(4'h2, 32'h0);
        t_force();
        t_normal();
        t_ctc();
        t_pwm();
        tally_and_finish();
    end
endmodule
